// *** rtl/ocb_config_slave.sv ***
// Serial block-write slave that holds the per-output enable bytes and
// gates eighteen buffered clocks. Assumes an open-drain bus with pull-ups.
module ocb_config_slave
	import ocb_pkg::*;
(
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Buffered clock source and gated outputs
	input wire logic buf_clk_in,
	input wire logic buf_rst_n,
	output logic [OCB_NUM_OUT-1:0] buf_clk_out,
	// Serial bus, open drain
	input wire logic serial_bus_clock_line,
	input wire logic serial_bus_data_line,
	output logic serial_bus_data_line_out,
	output logic serial_bus_data_line_oe,
	output logic serial_bus_clock_line_out,
	output logic serial_bus_clock_line_oe,
	// Power control and status
	input wire logic power_down_n,
	output logic [OCB_NUM_OUT-1:0] out_enable,
	output logic msg_valid
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [1:0] scl_sync; // Bit 0 read only by bit 1
	logic [1:0] sda_sync; // Bit 0 read only by bit 1
	logic [1:0] pd_sync; // Power-down level crossing
	ocb_lines_t lines; // Synchronised lines
	ocb_lines_t lines_prev; // One cycle older
	// Two flops on each pin; no glitch filter needed at standard mode.
	// Oversampling a 100 kbit/s bus at 20 MHz leaves wide margins.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			pd_sync <= 2'h3;
			lines_prev <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			scl_sync <= {scl_sync[0], serial_bus_clock_line};
			sda_sync <= {sda_sync[0], serial_bus_data_line};
			pd_sync <= {pd_sync[0], power_down_n};
			lines_prev <= lines;
		end
	end
	assign lines = '{scl: scl_sync[1], sda: sda_sync[1]};
	wire powered = pd_sync[1]; // Low while powered down
	// Edge and condition decode
	wire scl_rise = lines.scl & ~lines_prev.scl;
	wire scl_fall = ~lines.scl & lines_prev.scl;
	wire bus_start = lines.scl & lines_prev.scl & lines_prev.sda & ~lines.sda;
	wire bus_stop = lines.scl & lines_prev.scl & ~lines_prev.sda & lines.sda;
	// ----------------------------------------
	// Protocol state
	// ----------------------------------------
	ocb_state_t state; // Receiver phase
	ocb_state_t next_state;
	logic [7:0] shift; // Incoming byte
	logic [2:0] bit_cnt; // Bits taken in this byte
	logic [5:0] byte_idx; // Bytes after address in message
	logic addressed; // Address byte matched
	logic ack_drive; // Pulling data low for acknowledge
	logic [23:0] ack_cyc; // Length of current acknowledge hold
	logic [7:0] cfg [OCB_NUM_CFG]; // Enable bytes, kept through power-down
	logic valid; // Count byte acknowledged
	logic ack_seen_rise; // Ninth clock has risen
	logic resume; // One-cycle request to restart bit counting
	// Byte complete on the eighth rising edge
	wire byte_done = scl_rise && (state == OCB_RECV) && (bit_cnt == OCB_BIT_LAST);
	wire [7:0] full_byte = {shift[6:0], lines.sda};
	wire addr_hit = (full_byte[7:1] == OCB_SLAVE_ADDR) && !full_byte[0];
	wire first_byte = !addressed;
	wire take_ack = byte_done && (addressed || addr_hit);
	// Data position: count byte and command value are not checked
	wire [5:0] data_pos = byte_idx - OCB_IDX_DATA0;
	wire data_store = byte_done && addressed && powered && (byte_idx >= OCB_IDX_DATA0)
		&& (data_pos < 6'(OCB_NUM_CFG));
	wire ack_timeout = ack_cyc >= 24'(OCB_ACK_MAX_CYC);

	// Next state: ACK ends on the falling edge after the ninth clock.
	// The acknowledge walk is: eighth rise ends the byte, the next fall
	// starts the pull-down, the ninth rise is the host's sample point and
	// the ninth fall releases the line and resumes bit counting.
	// The bit counter has wrapped to zero on the eighth rise already, so
	// no extra clear is needed when receiving resumes.
	// A stuck acknowledge is cut by the hold cap and parks in SKIP.
	always_comb begin
		next_state = state;
		case (state)
			OCB_IDLE: begin
				next_state = OCB_IDLE;
			end
			OCB_RECV: begin
				if (byte_done) begin
					next_state = take_ack ? OCB_ACK : OCB_SKIP;
				end
			end
			OCB_ACK: begin
				if (ack_timeout) begin
					next_state = OCB_SKIP;
				end else if (resume) begin
					next_state = OCB_RECV;
				end
			end
			OCB_SKIP: begin
				next_state = OCB_SKIP;
			end
			default: begin
				next_state = OCB_IDLE;
			end
		endcase
		if (bus_start) begin
			next_state = OCB_RECV;
		end else if (bus_stop || !powered) begin
			next_state = OCB_IDLE;
		end
	end

	// Acknowledge phase tracking: drive on first fall, release on second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= OCB_IDLE;
			ack_seen_rise <= 1'b0;
			ack_drive <= 1'b0;
			ack_cyc <= '0;
		end else begin
			state <= next_state;
			if (next_state != OCB_ACK || state != OCB_ACK) begin
				ack_cyc <= '0;
			end else begin
				ack_cyc <= ack_cyc + 24'h000001;
			end
			if (state == OCB_ACK && next_state == OCB_ACK) begin
				if (scl_fall && !ack_drive) begin
					ack_drive <= 1'b1;
				end else if (scl_rise) begin
					ack_seen_rise <= 1'b1;
				end else if (scl_fall && ack_seen_rise) begin
					ack_drive <= 1'b0;
					ack_seen_rise <= 1'b0;
				end
			end else begin
				ack_drive <= 1'b0; // Release on timeout or stop
				ack_seen_rise <= 1'b0;
			end
		end
	end
	// Leave ACK back into RECV after release edge
	wire ack_end = (state == OCB_ACK) && scl_fall && ack_seen_rise;

	// Bit shifter, byte index and address flag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift <= '0;
			bit_cnt <= '0;
			byte_idx <= '0;
			addressed <= 1'b0;
		end else if (bus_start || bus_stop || !powered) begin
			bit_cnt <= '0;
			byte_idx <= '0;
			addressed <= 1'b0;
		end else if (scl_rise && state == OCB_RECV) begin
			shift <= full_byte;
			bit_cnt <= bit_cnt + 3'h1;
			if (byte_done && first_byte) begin
				addressed <= addr_hit;
			end else if (byte_done && byte_idx != OCB_IDX_MAX) begin
				byte_idx <= byte_idx + 6'h01;
			end
		end
	end

	// Enable bytes: updated per complete byte only, kept on stop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < OCB_NUM_CFG; i++) begin
				cfg[i] <= OCB_CFG_RESET;
			end
			valid <= 1'b0;
		end else begin
			if (data_store) begin
				cfg[data_pos[1:0]] <= full_byte;
			end
			if (bus_start) begin
				valid <= 1'b0;
			end else if (byte_done && addressed && byte_idx == OCB_IDX_CNT) begin
				valid <= 1'b1;
			end
		end
	end

	// Resume receiving after acknowledge; state register takes this override
	assign resume = ack_end;
	// ----------------------------------------
	// Pin drive and status
	// ----------------------------------------
	assign serial_bus_data_line_out = 1'b0; // Receiver only, no read-back
	assign serial_bus_data_line_oe = ack_drive && powered;
	assign serial_bus_clock_line_out = 1'b0;
	assign serial_bus_clock_line_oe = 1'b0; // No clock stretching
	assign out_enable = {cfg[2][7:6], cfg[1], cfg[0]};
	assign msg_valid = valid;

	// ----------------------------------------
	// Output gating in the buffered clock domain
	// ----------------------------------------
	logic [OCB_NUM_OUT-1:0] en_meta; // First stage, read only by en_sync
	logic [OCB_NUM_OUT-1:0] en_sync; // Settled enables
	logic [OCB_NUM_OUT-1:0] en_gate; // Changes only while source is low
	// Enables are static by design, so a per-bit level crossing suffices
	always_ff @(posedge buf_clk_in) begin
		if (!buf_rst_n) begin
			en_meta <= '1;
			en_sync <= '1;
		end else begin
			en_meta <= out_enable;
			en_sync <= en_meta;
		end
	end
	// Latch the gate on the falling edge so no runt pulse leaves
	always_ff @(negedge buf_clk_in) begin
		if (!buf_rst_n) begin
			en_gate <= '1;
		end else begin
			en_gate <= en_sync;
		end
	end
	assign buf_clk_out = {OCB_NUM_OUT{buf_clk_in}} & en_gate;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	addr_match_a: assert property (byte_done && first_byte && !addr_hit |=> !addressed)
		else $error("Foreign address was accepted");
	read_ignored_a: assert property (byte_done && first_byte && full_byte[0]
		|=> state != OCB_ACK)
		else $error("Read request acknowledged");
	no_stretch_a: assert property (!serial_bus_clock_line_oe)
		else $error("Clock line was held");
	hold_cap_a: assert property (ack_cyc <= 24'(OCB_ACK_MAX_CYC))
		else $error("Data line held too long");
	byte_store_a: assert property (data_store && data_pos == 6'h00
		|=> cfg[0] == $past(full_byte))
		else $error("Data byte not stored in order");
	stop_keep_a: assert property (bus_stop |=> $stable(out_enable))
		else $error("Stop disturbed stored bytes");
	count_valid_a: assert property (byte_done && addressed && byte_idx == OCB_IDX_CNT
		|=> msg_valid)
		else $error("Message not marked valid");
	start_index_a: assert property (bus_start |=> byte_idx == '0 && !addressed)
		else $error("Start did not reset index");
	pd_float_a: assert property (!powered |-> !serial_bus_data_line_oe)
		else $error("Line driven in power-down");
	map_a: assert property (out_enable[17:16] == cfg[2][7:6])
		else $error("Byte 2 map wrong");
	// The acknowledge pull-down only ever stands inside the ACK phase
	ack_drive_a: assert property (ack_drive |-> state == OCB_ACK)
		else $error("Acknowledge outside its phase");
	// Releasing the acknowledge hands the bus back to bit reception
	ack_resume_a: assert property (ack_end && !ack_timeout && !bus_start && !bus_stop
		&& powered |=> state == OCB_RECV)
		else $error("Receiver did not resume");
	// An idle receiver never pulls the data line
	idle_quiet_a: assert property (state == OCB_IDLE |-> !serial_bus_data_line_oe)
		else $error("Idle receiver drove data");
	// A refused message is skipped silently until the next condition
	skip_quiet_a: assert property (state == OCB_SKIP |-> !serial_bus_data_line_oe)
		else $error("Skipped message was acknowledged");
	// Byte 0 and byte 1 map straight onto the low sixteen enables
	low_map_a: assert property (out_enable[15:0] == {cfg[1], cfg[0]})
		else $error("Byte 0 or 1 map wrong");
	// Eight rises make a byte and the counter starts over
	bit_wrap_a: assert property (byte_done |=> bit_cnt == '0)
		else $error("Bit count did not wrap");
	// Bytes past the kept ones leave the enables alone
	surplus_a: assert property (byte_done && addressed && byte_idx >= OCB_IDX_DATA0
		&& data_pos >= 6'(OCB_NUM_CFG) |=> $stable(out_enable))
		else $error("Surplus byte was stored");
	// Power-down freezes the programming
	pd_keep_a: assert property (!powered |=> $stable(out_enable))
		else $error("Enables changed in power-down");
	// A new start withdraws the validity of the previous message
	valid_clear_a: assert property (bus_start |=> !msg_valid)
		else $error("Valid flag survived a start");
	// The byte index saturates rather than wrapping onto stored bytes
	idx_sat_a: assert property (byte_done && addressed && byte_idx == OCB_IDX_MAX
		&& !bus_start && !bus_stop |=> byte_idx == OCB_IDX_MAX)
		else $error("Byte index wrapped");
	ack_cov_c: cover property (ack_drive ##[1:400] !ack_drive);
	skip_cov_c: cover property (state == OCB_SKIP ##1 bus_stop);
	pd_cov_c: cover property (!powered);
	store_cov_c: cover property (data_store && data_pos == 6'h02);
	valid_cov_c: cover property (msg_valid ##1 bus_stop);
endmodule : ocb_config_slave

// *** rtl/ocb_pkg.sv ***
// Constants and types for the output-enable configuration slave.
// Assumes a 20 MHz system clock and a standard-mode serial host.
package ocb_pkg;
	// ----------------------------------------
	// Serial address and byte layout
	// ----------------------------------------
	localparam logic [6:0] OCB_SLAVE_ADDR = 7'h69; // Fixed slave address
	localparam int OCB_BYTE_BITS = 8; // Bits per byte
	localparam logic [2:0] OCB_BIT_LAST = 3'h7; // Index of eighth bit
	localparam logic [5:0] OCB_IDX_CMD = 6'h00; // Command code position
	localparam logic [5:0] OCB_IDX_CNT = 6'h01; // Byte count position
	localparam logic [5:0] OCB_IDX_DATA0 = 6'h02; // First data byte position
	localparam logic [5:0] OCB_IDX_MAX = 6'h3f; // Index saturates here
	localparam int OCB_NUM_CFG = 3; // Configuration bytes kept
	localparam int OCB_NUM_OUT = 18; // Gated clock outputs
	localparam logic [7:0] OCB_CFG_RESET = 8'hff; // All outputs enabled
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int OCB_CLK_HZ = 20000000; // System clock rate
	localparam int OCB_HOLD_MAX_US = 10000; // Longest line hold, 10 ms
	localparam int OCB_ACK_MAX_CYC = (OCB_CLK_HZ / 1000000) * OCB_HOLD_MAX_US; // Cap
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		OCB_IDLE = 3'h0,
		OCB_RECV = 3'h1,
		OCB_ACK = 3'h3,
		OCB_SKIP = 3'h2
	} ocb_state_t;
	typedef struct packed {
		logic scl; // Synchronised serial clock
		logic sda; // Synchronised serial data
	} ocb_lines_t;
endpackage : ocb_pkg

// *** test/ocb_host_model.sv ***
// Host model: bit-level serial writer for the configuration slave.
// Assumes pull-ups on both lines; the device only ever pulls low.
module ocb_host_model (
	// Timing reference
	input wire logic clk,
	// Device pull-down enables
	input wire logic dev_sda_oe,
	input wire logic dev_scl_oe,
	// Resolved line levels
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_h = 1'b1; // Host clock drive, 1 = released
	logic sda_h = 1'b1; // Host data drive, 1 = released
	// Pull-ups: a released line reads high, never the last value
	assign scl = scl_h & ~dev_scl_oe;
	assign sda = sda_h & ~dev_sda_oe;
	// Quarter bit of 2.5 us, so the bit rate is 100 kbit/s
	task automatic q;
		repeat (50) @(negedge clk);
	endtask : q
	// Start: data falls while clock is high
	task automatic start_c;
		sda_h = 1'b1;
		scl_h = 1'b1;
		q();
		sda_h = 1'b0;
		q();
		scl_h = 1'b0;
		q();
	endtask : start_c
	// Stop: data rises while clock is high; clock then idles high
	task automatic stop_c;
		sda_h = 1'b0;
		q();
		scl_h = 1'b1;
		q();
		sda_h = 1'b1;
		q();
	endtask : stop_c
	// Eight bits, most significant first, then the acknowledge slot
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_h = b[i];
			q();
			scl_h = 1'b1;
			q();
			q();
			scl_h = 1'b0;
			q();
		end
		sda_h = 1'b1;
		q();
		scl_h = 1'b1;
		q();
		ack = ~sda;
		q();
		scl_h = 1'b0;
		q();
	endtask : put_byte
endmodule : ocb_host_model

// *** test/ocb_config_slave_tb_top.sv ***
// Bench: block writes through the host model, then enables, gating,
// power-down and reset. Assumes ocb_pkg and the host model.
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin failures++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module ocb_config_slave_tb_top;
	import ocb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic buf_clk = 1'b0; // Link clock, 48 ns
	logic rst_n = 1'b0;
	logic power_down_n = 1'b1;
	logic scl, sda, sda_out, sda_oe, scl_out, scl_oe, msg_valid;
	logic [OCB_NUM_OUT-1:0] buf_clk_out, out_enable;
	int failures = 0;
	int n_compared = 0;
	initial forever #25 clk = ~clk;
	// Offset start keeps the two clocks unrelated in phase
	initial begin
		#7;
		forever #24 buf_clk = ~buf_clk;
	end
	ocb_config_slave ocb_config_slave_inst (.clk(clk), .rst_n(rst_n), .buf_clk_in(buf_clk),
		.buf_rst_n(rst_n), .buf_clk_out(buf_clk_out), .serial_bus_clock_line(scl),
		.serial_bus_data_line(sda), .serial_bus_data_line_out(sda_out),
		.serial_bus_data_line_oe(sda_oe), .serial_bus_clock_line_out(scl_out),
		.serial_bus_clock_line_oe(scl_oe), .power_down_n(power_down_n),
		.out_enable(out_enable), .msg_valid(msg_valid));
	ocb_host_model ocb_host_model_inst (.clk(clk), .dev_sda_oe(sda_oe), .dev_scl_oe(scl_oe),
		.scl(scl), .sda(sda));
	// Verdict, reached from the main sequence and the watchdog
	task automatic finish_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	// Full message; refused ones get one more byte that must not be acked
	task automatic write_msg(input logic [7:0] addr, input logic [7:0] cmd,
		input logic [7:0] cnt, input logic [39:0] data, input int nd, input logic exp_ack);
		logic a;
		ocb_host_model_inst.start_c();
		ocb_host_model_inst.put_byte(addr, a);
		`CHK("addr ack", exp_ack, a)
		if (exp_ack) begin
			ocb_host_model_inst.put_byte(cmd, a);
			`CHK("cmd ack", 1'b1, a)
			ocb_host_model_inst.put_byte(cnt, a);
			`CHK("count ack", 1'b1, a)
			for (int i = 0; i < nd; i++) begin
				ocb_host_model_inst.put_byte(data[39-8*i -: 8], a);
				`CHK("data ack", 1'b1, a)
				if (i == 0) `CHK("valid", 1'b1, msg_valid)
			end
		end else begin
			ocb_host_model_inst.put_byte(8'h00, a);
			`CHK("ignored ack", 1'b0, a)
			`CHK("valid", 1'b0, msg_valid)
		end
		ocb_host_model_inst.stop_c();
		repeat (10) @(negedge clk);
	endtask : write_msg
	// Enabled outputs follow the link clock, disabled ones stay low
	task automatic chk_gate(input logic [OCB_NUM_OUT-1:0] exp_en);
		for (int i = 0; i < 2; i++) begin
			@(posedge buf_clk);
			#10;
			`CHK("gated high", exp_en, buf_clk_out)
			@(negedge buf_clk);
			#10;
			`CHK("gated low", 18'h00000, buf_clk_out)
		end
	endtask : chk_gate
	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		$display("[ERR] watchdog expected end seen hang");
		finish_test();
	end
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("enables", 18'h3ffff, out_enable)
		chk_gate(18'h3ffff);
		write_msg(8'hd2, 8'h00, 8'h03, {8'ha5, 8'h3c, 8'h80, 16'h0000}, 3, 1'b1);
		`CHK("enables", {2'b10, 8'h3c, 8'ha5}, out_enable)
		chk_gate({2'b10, 8'h3c, 8'ha5});
		// Wrong address, read direction, general call
		write_msg(8'hd0, 8'h00, 8'h01, 40'h0, 1, 1'b0);
		write_msg(8'hd3, 8'h00, 8'h01, 40'h0, 1, 1'b0);
		write_msg(8'h00, 8'h00, 8'h01, 40'h0, 1, 1'b0);
		`CHK("enables", {2'b10, 8'h3c, 8'ha5}, out_enable)
		// Stop after byte 0; command and count values ignored
		write_msg(8'hd2, 8'h55, 8'h20, {8'h0f, 32'h0}, 1, 1'b1);
		`CHK("enables", {2'b10, 8'h3c, 8'h0f}, out_enable)
		// Surplus bytes beyond byte 2 are dropped
		write_msg(8'hd2, 8'h00, 8'h01, {8'hf0, 8'hc3, 8'h40, 8'h00, 8'h00}, 5, 1'b1);
		`CHK("enables", {2'b01, 8'hc3, 8'hf0}, out_enable)
		power_down_n = 1'b0;
		repeat (20) @(negedge clk);
		`CHK("pd enables", {2'b01, 8'hc3, 8'hf0}, out_enable)
		`CHK("pd sda oe", 1'b0, sda_oe)
		`CHK("scl oe", 1'b0, scl_oe)
		power_down_n = 1'b1;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("enables", 18'h3ffff, out_enable)
		finish_test();
	end
endmodule : ocb_config_slave_tb_top
